// [core/pts_pkg.sv]
// shared constants and types for the ptp timestamp port
package pts_pkg;

    // widths of the timestamp datapath
    localparam int PTS_TIMER_W = 80;
    localparam int PTS_TAG_W = 16;
    localparam int PTS_ADJ_W = 11;
    localparam int PTS_NS_W = 32;
    localparam int PTS_SEC_W = 48;
    localparam int PTS_TC_W = 64;

    // frame operation codes on the transmit command port
    typedef enum logic [1:0]
    {
        PTS_OP_NONE = 2'b00,
        PTS_OP_ONE = 2'b01,
        PTS_OP_TWO = 2'b10,
        PTS_OP_RSVD = 2'b11
    } pts_op_t;

    // apb register byte addresses
    localparam logic [11:0] PTS_REG_CTRL = 12'h000;
    localparam logic [11:0] PTS_REG_ADJ = 12'h004;
    localparam logic [11:0] PTS_REG_STAT = 12'h008;

    // control register fields
    localparam int PTS_CTRL_ONE_STEP = 0;
    localparam int PTS_CTRL_TRANSP = 1;
    localparam int PTS_CTRL_PATH_RST = 2;

    // status register fields
    localparam int PTS_STAT_WR_ERR = 0;
    localparam int PTS_STAT_RD_ERR = 1;
    localparam int PTS_STAT_EMPTY = 2;
    localparam int PTS_STAT_FULL = 3;

    // reset values
    localparam logic [1:0] PTS_CTRL_RESET = 2'h0;
    localparam logic [10:0] PTS_ADJ_RESET = 11'h000;

    // adjust value suggested for transparent clock use (802 decimal)
    localparam logic [10:0] PTS_ADJ_TRANSP_HINT = 11'h322;

    // time-of-day rollover and correction-field scaling
    localparam logic [31:0] PTS_NS_PER_SEC = 32'h3B9A_CA00;
    localparam int PTS_TC_FRAC_W = 16;
    localparam int PTS_ADJ_FRAC_W = 3;

    // cycles from the command port to the capture plane, and tag queue depth
    localparam int PTS_CAP_LAT = 4;
    localparam int PTS_TAG_DEPTH = 8;

endpackage

// [core/pts_tag_fifo.sv]
// tag queue between the command port and the capture plane
`timescale 1ns/1ps
`default_nettype none

module pts_tag_fifo
    import pts_pkg::*;
#(
    parameter int WIDTH = PTS_TAG_W,
    parameter int DEPTH = PTS_TAG_DEPTH
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic clr, // path reset, empties the queue
    input wire logic push, // store push_data
    input wire logic [WIDTH-1:0] push_data, // tag to store
    input wire logic pop, // drop the head entry
    output logic [WIDTH-1:0] head, // oldest tag
    output logic full, // no room left
    output logic empty // nothing stored
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // a push into a full queue with no pop in the same cycle, or a pop from an empty one, is dropped
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign full = (count == (AW+1)'(DEPTH));
    assign empty = (count == '0);
    assign head = mem[rd_ptr];

    // storage, written at the tail
    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem[wr_ptr] <= push_data;
    end

    // pointers and fill count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (clr)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + AW'(1);
            if (do_pop)
                rd_ptr <= rd_ptr + AW'(1);
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

endmodule // pts_tag_fifo

`default_nettype wire

// [core/pts_timestamp_port.sv]
// ptp packet timestamp port with apb control registers
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - normal mode timer: nanoseconds in low 32 bits, seconds in high 48
// RQ2 - transparent mode timer: nanoseconds bits 62:16, fraction bits 15:0
// RQ3 - timer source drives transmit timer synchronous to the clock
// RQ4 - transmit stamp valid marks a presented stamp and tag
// RQ5 - returned 16-bit tag equals the tag given with that frame
// RQ6 - transmit stamp is timer value when frame start hit capture plane
// RQ7 - client holds opcode and tag valid on frame's first cycle
// RQ8 - opcode 00 takes no stamp and leaves frame alone
// RQ9 - opcode 01 takes a stamp and offers it for insertion
// RQ10 - opcode 10 takes a stamp and returns it without frame change
// RQ11 - opcode 11 behaves exactly as opcode 00
// RQ12 - insertion happens only while one-step enable is 1
// RQ13 - transparent mode takes timer as correction value for the stamp
// RQ14 - client has already fixed correction field before transmit
// RQ15 - tag is ignored for no-operation frames
// RQ16 - one-step and two-step stamps come back with their tag
// RQ17 - one-step stamp offset by 11-bit adjust, ns bits 10:3, fraction 2:0
// RQ18 - controller should program adjust to 802 in transparent mode
// RQ19 - tag write failure sets a flag held until path reset
// RQ20 - tag read failure sets a flag held until path reset
// RQ21 - receive timer uses same format, synchronous to the clock
// RQ22 - receive stamp is valid on each frame's first cycle
// RQ23 - every received frame gets a stamp, no content parsing
// RQ24 - transmit stamp valid pulses one cycle with stable tag and stamp
module pts_timestamp_port
    import pts_pkg::*;
#(
    parameter int CAP_LAT = PTS_CAP_LAT,
    parameter int TAG_DEPTH = PTS_TAG_DEPTH
)
(
    input wire logic pclk, // system clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic tx_sop, // first cycle of a transmit frame
    input wire logic [1:0] tx_stamp_opcode, // per-frame operation
    input wire logic [15:0] tx_tag, // per-frame tag
    input wire logic [79:0] tx_timer, // transmit system timer
    output logic tx_stamp_valid, // stamp and tag presented
    output logic [15:0] tx_stamp_tag, // tag of stamped frame
    output logic [79:0] tx_stamp, // captured transmit stamp
    output logic tx_insert_valid, // one-step stamp for insertion
    output logic [79:0] tx_insert_stamp, // adjusted one-step stamp
    output logic tx_fifo_write_error, // sticky tag write failure
    output logic tx_fifo_read_error, // sticky tag read failure
    input wire logic [79:0] rx_timer, // receive system timer
    input wire logic rx_valid_in, // receive beat valid
    input wire logic rx_sop_in, // receive first beat
    output logic rx_valid, // receive beat valid, delayed
    output logic rx_sop, // receive first beat, delayed
    output logic rx_stamp_valid, // receive stamp on first beat
    output logic [79:0] rx_stamp // receive stamp
);

    localparam int CHK_DLY = CAP_LAT + 1;
    localparam int CHK_PLANE = CAP_LAT - 1;

    logic one_step_enable;
    logic transp_mode;
    logic [10:0] lat_adjust;
    logic path_clr;
    logic apb_wr;
    logic apb_rd_hit;
    logic stamp_op;
    logic tag_push;
    logic [CAP_LAT-1:0] pipe_hit;
    logic [CAP_LAT-1:0] pipe_one;
    logic plane_hit;
    logic plane_one;
    logic [15:0] tag_head;
    logic tag_full;
    logic tag_empty;
    logic [79:0] next_stamp;
    logic [79:0] next_insert;

    // apb access decode, zero wait states
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    always_comb
    begin
        apb_rd_hit = 1'b1;
        prdata = 32'h0000_0000;
        unique case (paddr)
            PTS_REG_CTRL:
            begin
                prdata[PTS_CTRL_ONE_STEP] = one_step_enable;
                prdata[PTS_CTRL_TRANSP] = transp_mode;
            end
            PTS_REG_ADJ:
                prdata[10:0] = lat_adjust;
            PTS_REG_STAT:
            begin
                prdata[PTS_STAT_WR_ERR] = tx_fifo_write_error;
                prdata[PTS_STAT_RD_ERR] = tx_fifo_read_error;
                prdata[PTS_STAT_EMPTY] = tag_empty;
                prdata[PTS_STAT_FULL] = tag_full;
            end
            default:
                apb_rd_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !apb_rd_hit;

    // control and adjust registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {transp_mode, one_step_enable} <= PTS_CTRL_RESET;
            lat_adjust <= PTS_ADJ_RESET;
        end
        else if (apb_wr)
        begin
            if (paddr == PTS_REG_CTRL)
            begin
                one_step_enable <= pwdata[PTS_CTRL_ONE_STEP];
                transp_mode <= pwdata[PTS_CTRL_TRANSP];
            end
            if (paddr == PTS_REG_ADJ)
                lat_adjust <= pwdata[10:0];
        end
    end

    // self-clearing transmit path reset, written as a one
    assign path_clr = apb_wr && (paddr == PTS_REG_CTRL)
        && pwdata[PTS_CTRL_PATH_RST];

    // only one-step and two-step frames are stamped
    assign stamp_op = tx_sop && ((tx_stamp_opcode == PTS_OP_ONE)
        || (tx_stamp_opcode == PTS_OP_TWO)); // RQ8 RQ11
    assign tag_push = stamp_op && !path_clr; // RQ15

    // frame start travels to the capture plane
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pipe_hit <= '0;
            pipe_one <= '0;
        end
        else if (path_clr)
        begin
            pipe_hit <= '0;
            pipe_one <= '0;
        end
        else
        begin
            pipe_hit <= {pipe_hit[CAP_LAT-2:0], stamp_op};
            pipe_one <= {pipe_one[CAP_LAT-2:0],
                tx_stamp_opcode == PTS_OP_ONE};
        end
    end
    assign plane_hit = pipe_hit[CAP_LAT-1];
    assign plane_one = pipe_one[CAP_LAT-1];

    // tags wait here until their frame reaches the plane
    pts_tag_fifo #(
        .WIDTH(PTS_TAG_W),
        .DEPTH(TAG_DEPTH)
    ) u_tag_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .clr(path_clr),
        .push(tag_push),
        .push_data(tx_tag),
        .pop(plane_hit),
        .head(tag_head),
        .full(tag_full),
        .empty(tag_empty)
    );

    // stamp format: tod as is, correction field zero-extended
    always_comb
    begin
        next_stamp = tx_timer; // RQ1 RQ6
        if (transp_mode)
            next_stamp = {16'h0000, tx_timer[PTS_TC_W-1:0]}; // RQ2 RQ13
    end

    // one-step stamp moved by the latency adjust
    always_comb
    begin
        logic [32:0] ns_sum;
        logic [63:0] tc_sum;
        ns_sum = {1'b0, tx_timer[PTS_NS_W-1:0]}
            + {25'h000_0000, lat_adjust[10:PTS_ADJ_FRAC_W]};
        tc_sum = tx_timer[PTS_TC_W-1:0] + {40'h00_0000_0000,
            lat_adjust, 13'h0000};
        next_insert = tx_timer;
        if (transp_mode)
            next_insert = {16'h0000, tc_sum}; // RQ17
        else if (ns_sum >= {1'b0, PTS_NS_PER_SEC})
        begin
            next_insert[PTS_NS_W-1:0] = 32'(ns_sum - {1'b0, PTS_NS_PER_SEC});
            next_insert[79:PTS_NS_W] = tx_timer[79:PTS_NS_W] + 48'h1;
        end
        else
            next_insert[PTS_NS_W-1:0] = ns_sum[31:0]; // RQ17
    end

    // stamp return to the client, one pulse per frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_stamp_valid <= 1'b0;
            tx_stamp_tag <= 16'h0000;
            tx_stamp <= 80'h0;
        end
        else
        begin
            tx_stamp_valid <= plane_hit; // RQ4 RQ10 RQ24
            if (plane_hit)
            begin
                tx_stamp_tag <= tag_head; // RQ5 RQ16
                tx_stamp <= next_stamp; // RQ6
            end
        end
    end

    // one-step stamp for the frame insertion logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_insert_valid <= 1'b0;
            tx_insert_stamp <= 80'h0;
        end
        else
        begin
            tx_insert_valid <= plane_hit && plane_one
                && one_step_enable; // RQ9 RQ12
            if (plane_hit && plane_one)
                tx_insert_stamp <= next_insert;
        end
    end

    // sticky tag queue errors, cleared only by a path reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_fifo_write_error <= 1'b0;
            tx_fifo_read_error <= 1'b0;
        end
        else
        begin
            // a fresh read error in the clearing cycle still sets the flag
            if (path_clr)
            begin
                tx_fifo_write_error <= 1'b0;
                tx_fifo_read_error <= 1'b0;
            end
            if (tag_push && tag_full && !plane_hit)
                tx_fifo_write_error <= 1'b1; // RQ19
            if (plane_hit && tag_empty)
                tx_fifo_read_error <= 1'b1; // RQ20
        end
    end

    // receive side stamps every first beat
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_valid <= 1'b0;
            rx_sop <= 1'b0;
            rx_stamp_valid <= 1'b0;
            rx_stamp <= 80'h0;
        end
        else
        begin
            rx_valid <= rx_valid_in;
            rx_sop <= rx_valid_in && rx_sop_in;
            rx_stamp_valid <= rx_valid_in && rx_sop_in; // RQ23
            if (rx_valid_in && rx_sop_in)
                rx_stamp <= rx_timer; // RQ21 RQ22
        end
    end

    // checks on the stamping behaviour
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_valid_cause: assert property ( // RQ4
        tx_stamp_valid |-> $past(plane_hit))
        else $error("stamp valid without a frame at the plane");

    chk_single_tag: assert property ( // RQ5
        (stamp_op && tag_empty && pipe_hit == '0 && !path_clr)
        ##1 !stamp_op ##CHK_PLANE plane_hit
        |=> tx_stamp_valid && tx_stamp_tag == $past(tx_tag, CHK_DLY))
        else $error("returned tag does not match the frame tag");

    chk_tod_capture: assert property ( // RQ6
        (plane_hit && !transp_mode) |=> tx_stamp == $past(tx_timer))
        else $error("stamp is not the timer at the capture plane");

    chk_noop_ignored: assert property ( // RQ8
        (tx_sop && tx_stamp_opcode == PTS_OP_NONE) |-> !tag_push)
        else $error("no-operation frame was queued");

    chk_one_step_ins: assert property ( // RQ9
        (plane_hit && plane_one && one_step_enable)
        |=> tx_insert_valid && tx_stamp_valid)
        else $error("one-step frame produced no insertion stamp");

    chk_two_step_ret: assert property ( // RQ10
        (plane_hit && !plane_one) |=> tx_stamp_valid && !tx_insert_valid)
        else $error("two-step frame handled wrongly");

    chk_reserved_op: assert property ( // RQ11
        (tx_sop && tx_stamp_opcode == PTS_OP_RSVD) |=> !pipe_hit[0])
        else $error("reserved opcode started a capture");

    chk_insert_gate: assert property ( // RQ12
        tx_insert_valid |-> $past(one_step_enable))
        else $error("insertion while one-step is disabled");

    chk_transp_format: assert property ( // RQ13
        (plane_hit && transp_mode) |=> tx_stamp[79:64] == 16'h0000
        && tx_stamp[63:0] == $past(tx_timer[63:0]))
        else $error("transparent stamp is not the correction value");

    chk_adjust_offset: assert property ( // RQ17
        (plane_hit && plane_one && transp_mode && one_step_enable)
        |=> tx_insert_stamp[63:0] == tx_stamp[63:0]
        + {40'h00_0000_0000, $past(lat_adjust), 13'h0000})
        else $error("one-step stamp not offset by the adjust");

    chk_wr_err_sticky: assert property ( // RQ19
        (tx_fifo_write_error && !path_clr) |=> tx_fifo_write_error)
        else $error("write error flag dropped without path reset");

    chk_rd_err_sticky: assert property ( // RQ20
        (tx_fifo_read_error && !path_clr) |=> tx_fifo_read_error)
        else $error("read error flag dropped without path reset");

    chk_rx_stamp: assert property ( // RQ22
        (rx_valid_in && rx_sop_in) |=> rx_sop && rx_stamp_valid
        && rx_stamp == $past(rx_timer))
        else $error("receive stamp not on the first beat");

    chk_valid_pulse: assert property ( // RQ24
        (plane_hit && !pipe_hit[CAP_LAT-2])
        |=> tx_stamp_valid ##1 !tx_stamp_valid)
        else $error("stamp valid is not a single pulse");

    cov_two_step: cover property (
        plane_hit && !plane_one ##1 tx_stamp_valid);
    cov_one_step: cover property (tx_insert_valid);
    cov_wr_error: cover property ($rose(tx_fifo_write_error));
    cov_rx_stamp: cover property (rx_stamp_valid);

endmodule // pts_timestamp_port

`default_nettype wire

// [test/pts_peer.sv]
// client and timer source model facing the timestamp port
`timescale 1ns/1ps
`default_nettype none

module pts_peer
    import pts_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    output logic tx_sop, // transmit frame start
    output logic [1:0] tx_stamp_opcode, // per-frame operation
    output logic [15:0] tx_tag, // per-frame tag
    output logic [79:0] tx_timer, // transmit timer
    output logic rx_valid_in, // receive beat valid
    output logic rx_sop_in, // receive first beat
    output logic [79:0] rx_timer // receive timer
);
    logic [47:0] sec;
    logic [31:0] ns;
    logic load_en = 1'b0;
    logic [31:0] load_ns = 32'h0000_0000;

    // idle levels at time zero
    initial
    begin
        tx_sop = 1'b0;
        tx_stamp_opcode = 2'b00;
        tx_tag = 16'h0000;
        rx_valid_in = 1'b0;
        rx_sop_in = 1'b0;
    end

    // time of day, one ns per clock, rolls into seconds
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec <= 48'h0001_0000_0abc;
            ns <= 32'h0000_0000;
        end
        else if (load_en)
            ns <= load_ns;
        else if (ns == PTS_NS_PER_SEC - 32'h0000_0001)
        begin
            ns <= 32'h0000_0000;
            sec <= sec + 48'h0000_0000_0001;
        end
        else
            ns <= ns + 32'h0000_0001;
    end

    // both timers follow pclk; receive side offset in seconds
    assign tx_timer = {sec, ns};
    assign rx_timer = {sec + 48'h0000_0000_0100, ns};

    // jump the ns count, entered just after a rising edge
    task automatic set_ns(input logic [31:0] v);
        load_ns <= v;
        load_en <= 1'b1;
        @(posedge pclk);
        load_en <= 1'b0;
    endtask

    // n back-to-back frame starts, tags counting up from tag0
    task automatic tx_burst(input int n, input logic [1:0] op,
        input logic [15:0] tag0, output logic [79:0] t[8]);
        for (int i = 0; i < n; i++)
        begin
            tx_sop <= 1'b1;
            tx_stamp_opcode <= op;
            tx_tag <= tag0 + 16'(i);
            @(posedge pclk);
            t[i] = tx_timer;
        end
        // outside frames the command lines carry junk
        tx_sop <= 1'b0;
        tx_stamp_opcode <= ~op;
        tx_tag <= ~tag0;
    endtask

    // one receive beat, returns the timer at the taking edge
    task automatic rx_beat(input logic sop, output logic [79:0] t);
        rx_valid_in <= 1'b1;
        rx_sop_in <= sop;
        @(posedge pclk);
        t = rx_timer;
        rx_valid_in <= 1'b0;
        rx_sop_in <= 1'b0;
    endtask
endmodule // pts_peer

`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the ptp timestamp port
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import pts_pkg::*;
;
    localparam int LAT = 4;
    localparam int DEPTH = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, transp;
    logic tx_sop, tx_stamp_valid, tx_insert_valid;
    logic tx_fifo_write_error, tx_fifo_read_error;
    logic rx_valid_in, rx_sop_in, rx_valid, rx_sop, rx_stamp_valid;
    logic [1:0] tx_stamp_opcode;
    logic [15:0] tx_tag, tx_stamp_tag;
    logic [79:0] tx_timer, tx_stamp, tx_insert_stamp, rx_timer, rx_stamp;
    logic [10:0] adj;
    logic [15:0] q_tag[$];
    logic [79:0] q_stamp[$];
    logic [79:0] q_ins[$];
    int q_cyc[$];
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    pts_timestamp_port #(.CAP_LAT(LAT), .TAG_DEPTH(DEPTH)) i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_sop(tx_sop),
        .tx_stamp_opcode(tx_stamp_opcode), .tx_tag(tx_tag),
        .tx_timer(tx_timer), .tx_stamp_valid(tx_stamp_valid),
        .tx_stamp_tag(tx_stamp_tag), .tx_stamp(tx_stamp),
        .tx_insert_valid(tx_insert_valid),
        .tx_insert_stamp(tx_insert_stamp),
        .tx_fifo_write_error(tx_fifo_write_error),
        .tx_fifo_read_error(tx_fifo_read_error), .rx_timer(rx_timer),
        .rx_valid_in(rx_valid_in), .rx_sop_in(rx_sop_in),
        .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_stamp_valid(rx_stamp_valid), .rx_stamp(rx_stamp)
    );

    pts_peer u_peer
    (
        .pclk(pclk), .presetn(presetn), .tx_sop(tx_sop),
        .tx_stamp_opcode(tx_stamp_opcode), .tx_tag(tx_tag),
        .tx_timer(tx_timer), .rx_valid_in(rx_valid_in),
        .rx_sop_in(rx_sop_in), .rx_timer(rx_timer)
    );

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // cycle count and log of returned stamps
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (tx_stamp_valid === 1'b1)
        begin
            q_tag.push_back(tx_stamp_tag);
            q_stamp.push_back(tx_stamp);
            q_cyc.push_back(cyc);
        end
        if (tx_insert_valid === 1'b1)
            q_ins.push_back(tx_insert_stamp);
    end

    task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; read data and error land in rd and err
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cfg(input logic [2:0] ctrl, input logic [10:0] a);
        apb(1'b1, PTS_REG_CTRL, 32'(ctrl));
        apb(1'b1, PTS_REG_ADJ, 32'(a));
        transp = ctrl[1];
        adj = a;
    endtask

    function automatic logic [79:0] tod_add(input logic [79:0] t,
        input logic [31:0] d);
        logic [31:0] ns;
        logic [47:0] sec;
        ns = t[31:0] + d;
        sec = t[79:32];
        if (ns >= PTS_NS_PER_SEC)
        begin
            ns = ns - PTS_NS_PER_SEC;
            sec = sec + 48'h0000_0000_0001;
        end
        return {sec, ns};
    endfunction

    // send n frames and judge every stamp and insertion returned
    task automatic frames(input int n, input logic [1:0] op,
        input logic [15:0] tag, input logic ins);
        logic [79:0] t[8];
        logic [79:0] t4;
        int c;
        int k;
        q_tag.delete();
        q_stamp.delete();
        q_ins.delete();
        q_cyc.delete();
        u_peer.tx_burst(n, op, tag, t);
        c = cyc - n + 1;
        repeat (LAT + 8) @(posedge pclk);
        k = (op == PTS_OP_ONE || op == PTS_OP_TWO) ? n : 0;
        cmp(80'(q_tag.size()), 80'(k));
        cmp(80'(q_ins.size()), ins ? 80'(k) : 80'h0);
        for (int i = 0; i < k && i < q_tag.size(); i++)
        begin
            t4 = tod_add(t[i], 32'(LAT));
            cmp(80'(q_tag[i]), 80'(tag + 16'(i)));
            cmp(80'(q_cyc[i] - c - i), 80'(LAT + 1));
            cmp(q_stamp[i], transp ? {16'h0000, t4[63:0]} : t4);
            if (ins && i < q_ins.size())
                cmp(q_ins[i], transp ?
                    {16'h0000, t4[63:0] + (64'(adj) << 13)} :
                    tod_add(t4, 32'(adj[10:3])));
        end
    endtask

    task automatic t_regs;
        apb(1'b0, PTS_REG_CTRL, 32'h0000_0000);
        cmp(80'(rd), 80'h0);
        apb(1'b0, PTS_REG_ADJ, 32'h0000_0000);
        cmp(80'(rd), 80'h0);
        apb(1'b0, PTS_REG_STAT, 32'h0000_0000);
        cmp(80'(rd), 80'h4);
        apb(1'b1, PTS_REG_ADJ, 32'hffff_ffff);
        apb(1'b0, PTS_REG_ADJ, 32'h0000_0000);
        cmp(80'(rd), 80'h7ff);
        apb(1'b1, PTS_REG_STAT, 32'hffff_ffff);
        apb(1'b0, PTS_REG_STAT, 32'h0000_0000);
        cmp(80'(rd), 80'h4);
        apb(1'b1, PTS_REG_CTRL, 32'h0000_0007);
        apb(1'b0, PTS_REG_CTRL, 32'h0000_0000);
        cmp(80'(rd), 80'h3);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        cmp(80'({err, rd}), 80'({1'b1, 32'h0000_0000}));
    endtask

    task automatic t_ops;
        cfg(3'h1, 11'h0a5);
        frames(1, PTS_OP_NONE, 16'h1100, 1'b0);
        frames(1, PTS_OP_ONE, 16'h1101, 1'b1);
        frames(1, PTS_OP_TWO, 16'h1102, 1'b0);
        frames(1, PTS_OP_RSVD, 16'h1103, 1'b0);
        frames(DEPTH, PTS_OP_TWO, 16'h2200, 1'b0);
        cfg(3'h0, 11'h0a5);
        frames(1, PTS_OP_ONE, 16'h1104, 1'b0);
    endtask

    task automatic t_rollover;
        cfg(3'h1, 11'h0ff);
        u_peer.set_ns(PTS_NS_PER_SEC - 32'h0000_000c);
        frames(1, PTS_OP_ONE, 16'h3300, 1'b1);
    endtask

    task automatic t_transp;
        cfg(3'h3, PTS_ADJ_TRANSP_HINT);
        frames(1, PTS_OP_TWO, 16'h4400, 1'b0);
        frames(1, PTS_OP_ONE, 16'h4401, 1'b1);
    endtask

    task automatic t_errors;
        logic [79:0] t[8];
        cfg(3'h0, 11'h000);
        u_peer.tx_burst(DEPTH + 2, PTS_OP_TWO, 16'h5500, t);
        repeat (LAT + 8) @(posedge pclk);
        // dropped tags leave later frames with an empty queue
        cmp(80'({tx_fifo_write_error, tx_fifo_read_error}), 80'h3);
        cfg(3'h4, 11'h000);
        cmp(80'({tx_fifo_write_error, tx_fifo_read_error}), 80'h0);
        u_peer.tx_burst(1, PTS_OP_TWO, 16'h5600, t);
        cfg(3'h4, 11'h000);
        repeat (LAT + 8) @(posedge pclk);
        // the path reset flushes the frame in flight, no error follows
        cmp(80'({tx_fifo_write_error, tx_fifo_read_error}), 80'h0);
        cfg(3'h4, 11'h000);
        cmp(80'(tx_fifo_read_error), 80'h0);
    endtask

    task automatic t_rx;
        logic [79:0] t;
        for (int i = 0; i < 4; i++)
        begin
            u_peer.rx_beat(i[0] == 1'b0, t);
            @(negedge pclk);
            cmp(80'({rx_valid, rx_sop, rx_stamp_valid}),
                i[0] ? 80'h4 : 80'h7);
            if (!i[0])
                cmp(rx_stamp, t);
            @(posedge pclk);
        end
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        transp = 1'b0;
        adj = 11'h000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_ops();
        t_rollover();
        t_transp();
        t_errors();
        t_rx();
        end_sim();
    end

    // hang guard, far beyond the length of all scenarios
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
